// file: rtl/switch_table_indirect_access.sv
// Purpose: Indirect register access to the VLAN entry read-back, the VLAN
//          pending flag and the DIFFSERV priority table.
// Assumes: A simple synchronous register port; read data follows one
//          cycle after the read strobe.
// Notes: A DIFFSERV access occupies one cycle after its command write.
//        A command written during an access is queued behind it.
//
// Notes on behaviour
// - Read-back bit 13 shows port 0 membership of the VLAN entry.
// - Read-back bit 12 shows port 0 untag flag of the entry.
// - Bits 11:0 hold the VLAN identifier; zero means disabled.
// - VLAN status bit 0 is a self-clearing, read-only pending flag.
// - Each DIFFSERV command write launches exactly one table access.
// - Command bit 7: one reads, zero writes; resets to zero.
// - Command bits 5:0 select the table entry; reset to zero.
// - Each entry stores a 3-bit priority; write data resets zero.
// - Table is not cleared at reset; software initialises it.
// - Read data holds the last completed read's priority, read-only.
// - DIFFSERV status bit 0 is a self-clearing pending flag.
// - A member flag admits matching frames and joins egress domain.
// - IP priority without precedence takes queue from table lookup.
module switch_table_indirect_access (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [switch_table_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [switch_table_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [switch_table_pkg::DATA_W-1:0] reg_rdata_o,
    // VLAN engine side.
    input wire logic vlan_busy_i,
    input wire logic vlan_entry_member_p0_i,
    input wire logic vlan_entry_untag_p0_i,
    input wire logic [switch_table_pkg::VID_W-1:0] vlan_entry_vid_i,
    output logic [switch_table_pkg::ENTRY_LOW_W-1:0] vlan_entry_low_o,
    // Port 0 VLAN filtering.
    input wire logic frame_valid_i,
    input wire logic [switch_table_pkg::VID_W-1:0] frame_vid_i,
    output logic p0_ingress_admit_o,
    output logic p0_egress_member_o,
    // Priority selection.
    input wire logic use_ip_i,
    input wire logic use_precedence_i,
    input wire logic ipv4_frame_i,
    input wire logic [switch_table_pkg::IDX_W-1:0] frame_tos_i,
    output logic [switch_table_pkg::PRIO_W-1:0] table_prio_o,
    output logic table_prio_valid_o
);
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } acc_state_t;

    diffserv_table_if tbl_if ();

    diffserv_table #(
        .DEPTH(1 << switch_table_pkg::IDX_W)
    ) u_table (
        .mclk_i(mclk_i),
        .tbl(tbl_if)
    );

    acc_state_t state_ff, nxt_state;
    logic dir_ff, nxt_dir;
    logic [switch_table_pkg::IDX_W-1:0] idx_ff, nxt_idx;
    logic [switch_table_pkg::PRIO_W-1:0] wr_prio_ff, nxt_wr_prio;
    logic [switch_table_pkg::PRIO_W-1:0] rd_prio_ff, nxt_rd_prio;
    logic ds_pending_ff, nxt_ds_pending;
    logic vlan_pending_ff, nxt_vlan_pending;
    logic [switch_table_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [switch_table_pkg::ENTRY_LOW_W-1:0] entry_ff, nxt_entry;
    logic admit_ff, nxt_admit;
    logic egress_ff, nxt_egress;
    logic [switch_table_pkg::PRIO_W-1:0] prio_ff, nxt_prio;
    logic prio_valid_ff, nxt_prio_valid;
    logic cmd_wr;
    logic wdata_wr;
    logic sel_vlan_sts;
    logic sel_ds_cmd;
    logic sel_ds_wr_data;
    logic sel_ds_rd_data;
    logic sel_ds_sts;
    logic [switch_table_pkg::DATA_W-1:0] vlan_sts_word;
    logic [switch_table_pkg::DATA_W-1:0] ds_cmd_word;
    logic [switch_table_pkg::DATA_W-1:0] ds_wr_data_word;
    logic [switch_table_pkg::DATA_W-1:0] ds_rd_data_word;
    logic [switch_table_pkg::DATA_W-1:0] ds_sts_word;
    logic vid_match;

    // One decoder feeds both paths, so writes and reads can never
    // disagree on which register a number selects.
    always_comb begin
        sel_vlan_sts = (reg_addr_i == switch_table_pkg::VLAN_CMD_STS_ADDR);
        sel_ds_cmd = (reg_addr_i == switch_table_pkg::DS_CMD_ADDR);
        sel_ds_wr_data = (reg_addr_i == switch_table_pkg::DS_WR_DATA_ADDR);
        sel_ds_rd_data = (reg_addr_i == switch_table_pkg::DS_RD_DATA_ADDR);
        sel_ds_sts = (reg_addr_i == switch_table_pkg::DS_CMD_STS_ADDR);
        cmd_wr = reg_wr_i && sel_ds_cmd;
        wdata_wr = reg_wr_i && sel_ds_wr_data;
    end

    // Each word is built with its reserved bits at zero.
    always_comb begin
        vlan_sts_word = '0;
        vlan_sts_word[switch_table_pkg::PENDING_BIT] =
            vlan_pending_ff;
        ds_cmd_word = '0;
        ds_cmd_word[switch_table_pkg::DIR_BIT] = dir_ff;
        ds_cmd_word[switch_table_pkg::IDX_W-1:0] = idx_ff;
        ds_wr_data_word = '0;
        ds_wr_data_word[switch_table_pkg::PRIO_W-1:0] = wr_prio_ff;
        ds_rd_data_word = '0;
        ds_rd_data_word[switch_table_pkg::PRIO_W-1:0] =
            rd_prio_ff;
        ds_sts_word = '0;
        ds_sts_word[switch_table_pkg::PENDING_BIT] =
            ds_pending_ff;
    end

    // Command and table access sequencing.
    always_comb begin
        nxt_state = state_ff;
        nxt_dir = dir_ff;
        nxt_idx = idx_ff;
        nxt_rd_prio = rd_prio_ff;
        nxt_ds_pending = ds_pending_ff;
        tbl_if.wr_en = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_state = ST_IDLE;
            end
            ST_RUN: begin
                // The stored command is carried out in this cycle.
                if (dir_ff == switch_table_pkg::DIR_READ) begin
                    nxt_rd_prio = tbl_if.acc_prio;
                end else begin
                    tbl_if.wr_en = 1'b1;
                end
                nxt_state = ST_IDLE;
                nxt_ds_pending = 1'b0;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_ds_pending = 1'b0;
            end
        endcase
        // A command arriving during an access queues the next one, and
        // its set of pending wins over the self-clear.
        if (cmd_wr) begin
            nxt_dir = reg_wdata_i[switch_table_pkg::DIR_BIT];
            nxt_idx = reg_wdata_i[switch_table_pkg::IDX_W-1:0];
            nxt_state = ST_RUN;
            nxt_ds_pending = 1'b1;
        end
        tbl_if.acc_idx = idx_ff;
        tbl_if.wr_prio = wr_prio_ff;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            dir_ff <= switch_table_pkg::DIR_RST;
            idx_ff <= switch_table_pkg::IDX_RST;
            rd_prio_ff <= switch_table_pkg::PRIO_RST;
            ds_pending_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            dir_ff <= nxt_dir;
            idx_ff <= nxt_idx;
            rd_prio_ff <= nxt_rd_prio;
            ds_pending_ff <= nxt_ds_pending;
        end
    end

    // Write data may change while an access runs; a write access takes
    // the value held in the cycle in which it is carried out.
    always_comb begin
        nxt_wr_prio = wr_prio_ff;
        if (wdata_wr) begin
            // Only the priority field is stored.
            nxt_wr_prio =
                reg_wdata_i[switch_table_pkg::PRIO_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_prio_ff <= switch_table_pkg::PRIO_RST;
        end else begin
            wr_prio_ff <= nxt_wr_prio;
        end
    end

    // The VLAN engine owns its accesses; its busy level is only mirrored.
    always_comb begin
        nxt_vlan_pending = vlan_busy_i;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            vlan_pending_ff <= 1'b0;
        end else begin
            vlan_pending_ff <= nxt_vlan_pending;
        end
    end

    // Register read-back; unmapped numbers read zero.
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd_i) begin
            if (sel_vlan_sts) begin
                nxt_rdata = vlan_sts_word;
            end else if (sel_ds_cmd) begin
                nxt_rdata = ds_cmd_word;
            end else if (sel_ds_wr_data) begin
                nxt_rdata = ds_wr_data_word;
            end else if (sel_ds_rd_data) begin
                nxt_rdata = ds_rd_data_word;
            end else if (sel_ds_sts) begin
                nxt_rdata = ds_sts_word;
            end else begin
                nxt_rdata = '0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // VLAN entry low field, shown one cycle after the engine presents it.
    always_comb begin
        nxt_entry = '0;
        nxt_entry[switch_table_pkg::MEMBER_P0_BIT] =
            vlan_entry_member_p0_i;
        nxt_entry[switch_table_pkg::UNTAG_P0_BIT] =
            vlan_entry_untag_p0_i;
        nxt_entry[switch_table_pkg::VID_W-1:0] = vlan_entry_vid_i;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            entry_ff <= '0;
        end else begin
            entry_ff <= nxt_entry;
        end
    end

    // Port 0 filtering against the current entry.
    always_comb begin
        // A null identifier disables the entry, so it never matches.
        vid_match = frame_valid_i &&
            (vlan_entry_vid_i != switch_table_pkg::VID_NULL) &&
            (frame_vid_i == vlan_entry_vid_i);
        nxt_admit = vid_match && vlan_entry_member_p0_i;
        nxt_egress = vid_match && vlan_entry_member_p0_i;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            admit_ff <= 1'b0;
            egress_ff <= 1'b0;
        end else begin
            admit_ff <= nxt_admit;
            egress_ff <= nxt_egress;
        end
    end

    // Transmit queue from the table for IPv4 when precedence is off.
    // The table is read directly, so a write shows on the next lookup.
    always_comb begin
        tbl_if.lkp_idx = frame_tos_i;
        nxt_prio_valid = use_ip_i && !use_precedence_i &&
            ipv4_frame_i;
        nxt_prio = nxt_prio_valid ? tbl_if.lkp_prio :
            switch_table_pkg::PRIO_RST;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prio_ff <= switch_table_pkg::PRIO_RST;
            prio_valid_ff <= 1'b0;
        end else begin
            prio_ff <= nxt_prio;
            prio_valid_ff <= nxt_prio_valid;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign vlan_entry_low_o = entry_ff;
    assign p0_ingress_admit_o = admit_ff;
    assign p0_egress_member_o = egress_ff;
    assign table_prio_o = prio_ff;
    assign table_prio_valid_o = prio_valid_ff;
endmodule // switch_table_indirect_access

// file: rtl/switch_table_pkg.sv
// Purpose: Shared constants for the switch table indirect access block.
// Assumes: Registers are addressed by their printed register number.
// Notes: Widths and positions are named once here and used by name.
package switch_table_pkg;
    // Register numbers.
    localparam int ADDR_W = 16;
    localparam logic [15:0] VLAN_CMD_STS_ADDR = 16'h1810;
    localparam logic [15:0] DS_CMD_ADDR = 16'h1811;
    localparam logic [15:0] DS_WR_DATA_ADDR = 16'h1812;
    localparam logic [15:0] DS_RD_DATA_ADDR = 16'h1813;
    localparam logic [15:0] DS_CMD_STS_ADDR = 16'h1814;
    // Field layout.
    localparam int DATA_W = 32;
    localparam int PENDING_BIT = 0;
    localparam int DIR_BIT = 7;
    localparam int IDX_W = 6;
    localparam int PRIO_W = 3;
    localparam int VID_W = 12;
    localparam int MEMBER_P0_BIT = 13;
    localparam int UNTAG_P0_BIT = 12;
    localparam int ENTRY_LOW_W = 14;
    // Reset values and special identifiers.
    localparam logic [5:0] IDX_RST = 6'h00;
    localparam logic [2:0] PRIO_RST = 3'h0;
    localparam logic [11:0] VID_NULL = 12'h000;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_RST = 1'b0;
endpackage

// file: rtl/diffserv_table_if.sv
// Purpose: Carries table accesses between the controller and the table.
// Assumes: Single clock; all signals sampled on the rising edge.
// Notes: The lookup port is independent of the host access port.
interface diffserv_table_if;
    logic wr_en;
    logic [switch_table_pkg::IDX_W-1:0] acc_idx;
    logic [switch_table_pkg::PRIO_W-1:0] wr_prio;
    logic [switch_table_pkg::PRIO_W-1:0] acc_prio;
    logic [switch_table_pkg::IDX_W-1:0] lkp_idx;
    logic [switch_table_pkg::PRIO_W-1:0] lkp_prio;
    modport ctrl (
        output wr_en, acc_idx, wr_prio, lkp_idx,
        input acc_prio, lkp_prio
    );
    modport store (
        input wr_en, acc_idx, wr_prio, lkp_idx,
        output acc_prio, lkp_prio
    );
endinterface

// file: rtl/diffserv_table.sv
// Purpose: 64-entry priority table held in flip-flops.
// Assumes: Writes come from the controller one entry per cycle.
// Notes: Entries have no reset; software must load every entry.
module diffserv_table #(
    parameter int DEPTH = 64
) (
    // Clock.
    input wire logic mclk_i,
    // Table ports.
    diffserv_table_if.store tbl
);
    logic [switch_table_pkg::PRIO_W-1:0] mem_ff [DEPTH];
    logic [switch_table_pkg::PRIO_W-1:0] nxt_mem [DEPTH];

    // Contents survive reset, so no reset term here.
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (tbl.wr_en) begin
            nxt_mem[tbl.acc_idx] = tbl.wr_prio;
        end
    end

    always_ff @(posedge mclk_i) begin
        mem_ff <= nxt_mem;
    end

    assign tbl.acc_prio = mem_ff[tbl.acc_idx];
    assign tbl.lkp_prio = mem_ff[tbl.lkp_idx];
endmodule // diffserv_table

// file: testbench/switch_table_indirect_access_chk.sv
// Purpose: Port-level assertions for the switch table access block.
// Assumes: One clock; synchronous active-high reset.
// Notes: Table contents are unseen here; only port relations are checked.
module switch_table_indirect_access_chk (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Side ports.
    input wire logic vlan_busy_i,
    input wire logic vlan_entry_member_p0_i,
    input wire logic vlan_entry_untag_p0_i,
    input wire logic [11:0] vlan_entry_vid_i,
    input wire logic [13:0] vlan_entry_low_o,
    input wire logic [11:0] frame_vid_i,
    input wire logic p0_ingress_admit_o,
    input wire logic p0_egress_member_o,
    input wire logic use_ip_i,
    input wire logic use_precedence_i,
    input wire logic ipv4_frame_i,
    input wire logic [2:0] table_prio_o,
    input wire logic table_prio_valid_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    logic cmd_wr;
    assign cmd_wr = reg_wr_i && reg_addr_i == 16'h1811;
    sequence s_cmd_wr;
        cmd_wr;
    endsequence
    sequence s_sts_rd;
        reg_rd_i && reg_addr_i == 16'h1814;
    endsequence
    property p_low;
        !$past(rst_i) |-> vlan_entry_low_o == $past({vlan_entry_member_p0_i,
            vlan_entry_untag_p0_i, vlan_entry_vid_i});
    endproperty
    a_low: assert property (p_low) else $error("entry bits");
    property p_vsts;
        reg_rd_i && reg_addr_i == 16'h1810 && !$past(rst_i)
            |=> reg_rdata_o == {31'h0, $past(vlan_busy_i, 2)};
    endproperty
    a_vsts: assert property (p_vsts) else $error("vlan status");
    property p_pend;
        s_cmd_wr ##1 s_sts_rd |=> reg_rdata_o == 32'h1;
    endproperty
    a_pend: assert property (p_pend) else $error("pending set");
    // A command four or more cycles back must have finished.
    property p_idle;
        s_sts_rd ##0 !$past(cmd_wr) && !$past(cmd_wr, 2)
            && !$past(cmd_wr, 3) |=> reg_rdata_o == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("pending clear");
    property p_unmap;
        reg_rd_i && (reg_addr_i < 16'h1810 || reg_addr_i > 16'h1814)
            |=> reg_rdata_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_pvld;
        !$past(rst_i) |-> table_prio_valid_o
            == $past(use_ip_i && !use_precedence_i && ipv4_frame_i);
    endproperty
    a_pvld: assert property (p_pvld) else $error("prio valid");
    property p_pzero;
        !table_prio_valid_o |-> table_prio_o == 3'h0;
    endproperty
    a_pzero: assert property (p_pzero) else $error("prio zero");
    property p_admit;
        p0_ingress_admit_o || p0_egress_member_o |-> p0_ingress_admit_o
            && p0_egress_member_o && $past(vlan_entry_member_p0_i
            && vlan_entry_vid_i != 12'h0 && frame_vid_i == vlan_entry_vid_i);
    endproperty
    a_admit: assert property (p_admit) else $error("admit");
endmodule // switch_table_indirect_access_chk

bind switch_table_indirect_access switch_table_indirect_access_chk chk (.*);

// file: testbench/tb_switch_table_indirect_access.sv
// Purpose: Register-level test of the switch table access block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Table priorities follow a fixed pattern of the index.
module tb_switch_table_indirect_access;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, rst_i = 1'b1;
    logic [15:0] reg_addr_i = 16'h0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, got;
    logic vlan_busy_i = 1'b0, vlan_entry_member_p0_i = 1'b0;
    logic vlan_entry_untag_p0_i = 1'b0, frame_valid_i = 1'b1;
    logic [11:0] vlan_entry_vid_i = 12'h0, frame_vid_i = 12'h0;
    logic [13:0] vlan_entry_low_o;
    logic p0_ingress_admit_o, p0_egress_member_o, table_prio_valid_o;
    logic use_ip_i = 1'b0, use_precedence_i = 1'b0, ipv4_frame_i = 1'b0;
    logic [5:0] frame_tos_i = 6'h0;
    logic [2:0] table_prio_o;
    int n_fail = 0;
    int compares = 0;
    switch_table_indirect_access DUT (.*);
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] pat(input int i);
        return 32'((i * 3 + 1) % 8);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A strobe stays up between back-to-back accesses, so no signal is
    // set twice in one time step; bus_idle drops both strobes.
    task automatic wr(input logic [15:0] ad, input logic [31:0] d);
        reg_rd_i = 1'b0;
        reg_addr_i = ad;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge mclk_i);
    endtask
    task automatic rc(input logic [15:0] ad, input logic [31:0] e);
        reg_wr_i = 1'b0;
        reg_addr_i = ad;
        reg_rd_i = 1'b1;
        @(negedge mclk_i);
        got = reg_rdata_o;
        chk(got, e);
    endtask
    task automatic bus_idle;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        @(negedge mclk_i);
    endtask
    // Polls the pending flag under a bound; a stuck flag ends the run.
    task automatic poll;
        for (int i = 0; i < 8; i++) begin
            reg_wr_i = 1'b0;
            reg_addr_i = 16'h1814;
            reg_rd_i = 1'b1;
            @(negedge mclk_i);
            if (reg_rdata_o === 32'h0) return;
        end
        n_fail++;
        report_and_stop();
    endtask
    task automatic vcase(input logic [14:0] e, input logic [11:0] f,
                         input logic ad);
        {vlan_entry_member_p0_i, vlan_entry_untag_p0_i} = e[14:13];
        vlan_entry_vid_i = e[11:0];
        frame_vid_i = f;
        @(negedge mclk_i);
        chk({16'h0, vlan_entry_low_o, p0_ingress_admit_o, p0_egress_member_o},
            {16'h0, e[14:13], e[11:0], ad, ad});
    endtask
    initial begin
        repeat (12) @(negedge mclk_i);
        rst_i = 1'b0;
        for (int k = 16'h1810; k < 16'h1815; k++) begin
            rc(k[15:0], 32'h0);
        end
        rc(16'h180f, 32'h0);
        rc(16'h1815, 32'h0);
        wr(16'h1813, 32'h7);
        rc(16'h1813, 32'h0);
        wr(16'h1812, 32'hffff_fffd);
        rc(16'h1812, 32'h5);
        wr(16'h1811, 32'hffff_ff7f);
        rc(16'h1814, 32'h1);
        poll();
        rc(16'h1811, 32'h3f);
        for (int i = 0; i < 64; i++) begin
            wr(16'h1812, pat(i));
            wr(16'h1811, i);
            poll();
        end
        for (int i = 0; i < 64; i++) begin
            wr(16'h1811, 32'h80 | i);
            poll();
            rc(16'h1813, pat(i));
        end
        rc(16'h1811, 32'hbf);
        bus_idle();
        {use_ip_i, ipv4_frame_i} = 2'h3;
        for (int i = 0; i < 64; i++) begin
            frame_tos_i = i[5:0];
            @(negedge mclk_i);
            chk({table_prio_valid_o, table_prio_o}, 32'h8 | pat(i));
        end
        use_precedence_i = 1'b1;
        @(negedge mclk_i);
        chk({table_prio_valid_o, table_prio_o}, 32'h0);
        vlan_busy_i = 1'b1;
        bus_idle();
        rc(16'h1810, 32'h1);
        vlan_busy_i = 1'b0;
        bus_idle();
        rc(16'h1810, 32'h0);
        bus_idle();
        vcase(15'h4abc, 12'habc, 1'b1);
        vcase(15'h2123, 12'h123, 1'b0);
        vcase(15'h6000, 12'h000, 1'b0);
        vcase(15'h4abc, 12'habd, 1'b0);
        frame_valid_i = 1'b0;
        vcase(15'h4abc, 12'habc, 1'b0);
        report_and_stop();
    end
endmodule // tb_switch_table_indirect_access
